// [design/bdc_ctrl.sv]
// Purpose: Enable, shutdown, soft start, fault handling and dimming mode control
// Assumes: Fault indications come from comparators; bytes come from a one-wire decoder
// Notes:   Reference output is a digital millivolt value before the analog filter
`timescale 1ns/1ps
module bdc_ctrl
  import bdc_pkg::*;
#(
  parameter int unsigned STEP_CYC   = SS_STEP_CYC,
  parameter int unsigned SD_CYC     = SHUTDOWN_CYC,
  parameter int unsigned DELAY_CYC  = ENTRY_DELAY_CYC,
  parameter int unsigned LOW_CYC    = ENTRY_LOW_CYC,
  parameter int unsigned WINDOW_CYC = ENTRY_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  // Control pin and analog indications
  input  wire logic         ctrl_pin_in,
  input  wire bdc_fault_t   fault_in,
  // One-wire decoded bytes
  input  wire logic         ow_byte_valid_in,
  input  wire bdc_ow_byte_t ow_byte_in,
  // Power stage control
  output logic              switch_enable_out,
  output logic              ilim_half_out,
  output logic [7:0]        ref_mv_out,
  // Status
  output logic              shutdown_out,
  output bdc_mode_t         mode_out,
  output logic              open_latch_out,
  output logic              ow_ack_request_out,
  output logic [4:0]        level_out
);

  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  logic [SYNC_BITS-1:0] raw_bits;
  logic [SYNC_BITS-1:0] sync_bits;
  logic                 pin_s;
  bdc_fault_t           fault_s;
  logic                 pin_prev_q;

  assign raw_bits = {ctrl_pin_in, fault_in};

  bdc_sync #(
    .WIDTH (SYNC_BITS)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    (raw_bits),
    .sync_out    (sync_bits)
  );

  assign pin_s   = sync_bits[SYNC_BITS-1];
  assign fault_s = bdc_fault_t'(sync_bits[SYNC_BITS-2:0]);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  wire pin_rise = pin_s & ~pin_prev_q;

  // ----------------------------------------------------------------
  // Shutdown low-time detector
  // ----------------------------------------------------------------
  // Counter saturates so a pin parked low never wraps back to zero
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] low_cnt_d;
  logic             low_long_q;

  wire low_sat = (low_cnt_q == CNT_W'(SD_CYC));
  assign low_cnt_d = (pin_s || pin_rise) ? '0 :
                     low_sat ? low_cnt_q : low_cnt_q + CNT_W'(1);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_cnt_q  <= '0;
      low_long_q <= 1'b0;
    end else begin
      low_cnt_q  <= low_cnt_d;
      low_long_q <= ~pin_s & low_sat;
    end
  end

  // ----------------------------------------------------------------
  // Main state
  // ----------------------------------------------------------------
  bdc_state_t state_q;
  bdc_state_t state_d;

  wire hold_fault = fault_s.uvlo | fault_s.otp;
  wire open_fault = fault_s.output_overvoltage_threshold & fault_s.fb_low;
  wire enable_ev  = (state_q == BDC_ST_SHUT) & pin_rise;

  logic [CNT_W-1:0] step_cnt_q;
  logic [5:0]       ss_idx_q;
  wire              step_tick = (step_cnt_q == CNT_W'(STEP_CYC - 1));
  wire              ramp_done = (ss_idx_q == 6'(SS_STEPS)) & (state_q == BDC_ST_RAMP);

  always_comb begin
    state_d = state_q;
    case (state_q)
      BDC_ST_SHUT: begin
        if (enable_ev) begin
          state_d = hold_fault ? BDC_ST_HOLD : BDC_ST_RAMP;
        end
      end
      BDC_ST_RAMP, BDC_ST_RUN: begin
        if (low_long_q) begin
          state_d = BDC_ST_SHUT;
        end else if (open_fault) begin
          state_d = BDC_ST_OPEN_LATCH;
        end else if (hold_fault) begin
          state_d = BDC_ST_HOLD;
        end else if (ramp_done) begin
          state_d = BDC_ST_RUN;
        end
      end
      BDC_ST_HOLD: begin
        if (low_long_q) begin
          state_d = BDC_ST_SHUT;
        end else if (!hold_fault) begin
          state_d = BDC_ST_RAMP;
        end
      end
      BDC_ST_OPEN_LATCH: begin
        if (low_long_q) begin
          state_d = BDC_ST_SHUT;
        end
      end
      default: begin
        state_d = BDC_ST_SHUT;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= BDC_ST_SHUT;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Soft-start ramp
  // ----------------------------------------------------------------
  wire ramp_start = (state_d == BDC_ST_RAMP) & (state_q != BDC_ST_RAMP);
  wire in_ramp    = (state_q == BDC_ST_RAMP);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      step_cnt_q <= '0;
      ss_idx_q   <= '0;
    end else if (ramp_start || !in_ramp) begin
      step_cnt_q <= '0;
      ss_idx_q   <= in_ramp ? ss_idx_q : '0;
    end else if (step_tick) begin
      step_cnt_q <= '0;
      ss_idx_q   <= ss_idx_q + 6'd1;
    end else begin
      step_cnt_q <= step_cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Dimming mode detection
  // ----------------------------------------------------------------
  // Low must begin after the entry delay; lows that straddle it are
  // counted from the delay point, which only shortens what is seen
  logic [CNT_W-1:0] win_cnt_q;
  logic [CNT_W-1:0] det_cnt_q;
  logic             win_open_q;
  bdc_mode_t        mode_q;

  wire delay_done  = (win_cnt_q >= CNT_W'(DELAY_CYC));
  wire win_expired = (win_cnt_q >= CNT_W'(WINDOW_CYC));
  wire det_hit     = win_open_q & ~win_expired & (det_cnt_q == CNT_W'(LOW_CYC));
  wire powered     = (state_q == BDC_ST_RAMP) | (state_q == BDC_ST_RUN) | (state_q == BDC_ST_HOLD);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      win_cnt_q  <= '0;
      win_open_q <= 1'b0;
    end else if (enable_ev) begin
      win_cnt_q  <= '0;
      win_open_q <= 1'b1;
    end else if (!powered || win_expired || mode_q == BDC_MODE_ONE_WIRE) begin
      win_open_q <= 1'b0;
    end else begin
      win_cnt_q  <= win_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      det_cnt_q <= '0;
    end else if (pin_s || !delay_done || !win_open_q) begin
      det_cnt_q <= '0;
    end else if (det_cnt_q != CNT_W'(LOW_CYC)) begin
      det_cnt_q <= det_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_q <= BDC_MODE_PWM;
    end else if (enable_ev) begin
      mode_q <= BDC_MODE_PWM;
    end else if (det_hit) begin
      mode_q <= BDC_MODE_ONE_WIRE;
    end
  end

  // ----------------------------------------------------------------
  // Stored level and one-wire bytes
  // ----------------------------------------------------------------
  logic [4:0] level_q;
  logic       ack_q;

  wire ow_take = ow_byte_valid_in & powered & (mode_q == BDC_MODE_ONE_WIRE)
               & (ow_byte_in.addr == OW_ADDR);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      level_q <= LEVEL_RESET;
      ack_q   <= 1'b0;
    end else begin
      level_q <= ow_take ? ow_byte_in.level : level_q;
      ack_q   <= ow_take & ow_byte_in.ack_request_bit;
    end
  end

  // ----------------------------------------------------------------
  // Reference selection and chopping
  // ----------------------------------------------------------------
  // Chopping follows the pin each cycle, so 1 percent of a 50 us
  // period still spans fifty clocks and is not lost
  logic [7:0]  lut_mv;
  logic [7:0]  target_mv;
  logic [13:0] scaled;
  logic [7:0]  ref_d;

  bdc_level_lut u_lut (
    .level_in   (level_q),
    .ref_mv_out (lut_mv)
  );

  assign target_mv = (mode_q == BDC_MODE_ONE_WIRE) ? lut_mv :
                     (pin_s ? FULL_REF_MV : 8'h00_00);
  assign scaled    = 14'(target_mv) * 14'(ss_idx_q);
  assign ref_d     = !(state_q inside {BDC_ST_RAMP, BDC_ST_RUN}) ? 8'h00_00 :
                     in_ramp ? scaled[12:5] : target_mv;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      switch_enable_out <= 1'b0;
      ilim_half_out     <= 1'b0;
      ref_mv_out        <= 8'h00_00;
      shutdown_out      <= 1'b1;
      mode_out          <= BDC_MODE_PWM;
      open_latch_out    <= 1'b0;
      ow_ack_request_out <= 1'b0;
      level_out         <= LEVEL_RESET;
    end else begin
      switch_enable_out <= state_q inside {BDC_ST_RAMP, BDC_ST_RUN};
      ilim_half_out     <= in_ramp;
      ref_mv_out        <= ref_d;
      shutdown_out      <= (state_q == BDC_ST_SHUT);
      mode_out          <= mode_q;
      open_latch_out    <= (state_q == BDC_ST_OPEN_LATCH);
      ow_ack_request_out <= ack_q;
      level_out         <= level_q;
    end
  end

endmodule

// [design/bdc_pkg.sv]
// Purpose: Shared constants and types for the backlight dimming control block
// Assumes: 100 MHz core clock
// Notes:   Long cycle counts are top-level parameters; here they are defaults
package bdc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SS_STEP_US       = 341;
  localparam int unsigned SHUTDOWN_US      = 3500;
  localparam int unsigned ENTRY_DELAY_US   = 100;
  localparam int unsigned ENTRY_LOW_US     = 450;
  localparam int unsigned ENTRY_WINDOW_US  = 3500;
  localparam int unsigned SS_STEP_CYC      = SS_STEP_US * CLK_MHZ;
  localparam int unsigned SHUTDOWN_CYC     = SHUTDOWN_US * CLK_MHZ;
  localparam int unsigned ENTRY_DELAY_CYC  = ENTRY_DELAY_US * CLK_MHZ;
  localparam int unsigned ENTRY_LOW_CYC    = ENTRY_LOW_US * CLK_MHZ;
  localparam int unsigned ENTRY_WINDOW_CYC = ENTRY_WINDOW_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Soft start, levels and reference
  // ----------------------------------------------------------------
  localparam int unsigned     SS_STEPS    = 32;
  localparam int unsigned     LEVELS      = 32;
  localparam logic [7:0]      FULL_REF_MV = 8'h00_C8;
  localparam logic [4:0]      LEVEL_RESET = 5'h1F;
  localparam logic [1:0]      OW_ADDR     = 2'h0;
  localparam int unsigned     CNT_W       = 20;
  localparam int unsigned     SYNC_BITS   = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {BDC_MODE_PWM, BDC_MODE_ONE_WIRE} bdc_mode_t;

  typedef enum {BDC_ST_SHUT, BDC_ST_RAMP, BDC_ST_RUN, BDC_ST_HOLD, BDC_ST_OPEN_LATCH} bdc_state_t;

  typedef struct packed {
    logic uvlo;
    logic output_overvoltage_threshold;
    logic fb_low;
    logic otp;
  } bdc_fault_t;

  typedef struct packed {
    logic       ack_request_bit;
    logic [1:0] addr;
    logic [4:0] level;
  } bdc_ow_byte_t;

endpackage

// [design/bdc_sync.sv]
// Purpose: Two-flop synchroniser for a group of asynchronous levels
// Assumes: Inputs change slowly relative to the core clock
// Notes:   The first stage is read only by the second stage
`timescale 1ns/1ps
module bdc_sync
  import bdc_pkg::*;
#(
  parameter int unsigned WIDTH = SYNC_BITS
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // One synchroniser per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule

// [design/bdc_level_lut.sv]
// Purpose: Brightness code to reference millivolts
// Assumes: Code 31 is full scale
// Notes:   Pure combinational table
`timescale 1ns/1ps
module bdc_level_lut
  import bdc_pkg::*;
(
  // Lookup
  input  wire logic [4:0] level_in,
  output logic      [7:0] ref_mv_out
);

  // ----------------------------------------------------------------
  // Pseudo-logarithmic table, step grows with level above code 1
  // ----------------------------------------------------------------
  localparam logic [7:0] TABLE [LEVELS] = '{
    8'h00_00, 8'h00_05, 8'h00_08, 8'h00_0B, 8'h00_0E, 8'h00_11, 8'h00_14, 8'h00_17,
    8'h00_1A, 8'h00_1D, 8'h00_20, 8'h00_23, 8'h00_26, 8'h00_2C, 8'h00_32, 8'h00_38,
    8'h00_3E, 8'h00_44, 8'h00_4A, 8'h00_50, 8'h00_56, 8'h00_5C, 8'h00_62, 8'h00_68,
    8'h00_74, 8'h00_80, 8'h00_8C, 8'h00_98, 8'h00_A4, 8'h00_B0, 8'h00_BC, 8'h00_C8
  };

  assign ref_mv_out = TABLE[level_in];

endmodule

// [verif/bdc_ctrl_monitor.sv]
// Purpose: Port-level assertions for the dimming control block
// Assumes: One core clock domain, reset active high
// Notes:   Fault and pin latencies allow for the two-flop input synchroniser
`timescale 1ns/1ps
module bdc_ctrl_monitor
  import bdc_pkg::*;
#(
  parameter int unsigned STEP_CYC = SS_STEP_CYC,
  parameter int unsigned SD_CYC   = SHUTDOWN_CYC
) (
  // Clock and reset
  input wire logic         core_clk_in,
  input wire logic         reset_in,
  // Inputs
  input wire logic         ctrl_pin_in,
  input wire bdc_fault_t   fault_in,
  input wire logic         ow_byte_valid_in,
  input wire bdc_ow_byte_t ow_byte_in,
  // Outputs
  input wire logic         switch_enable_out,
  input wire logic         ilim_half_out,
  input wire logic [7:0]   ref_mv_out,
  input wire logic         shutdown_out,
  input wire bdc_mode_t    mode_out,
  input wire logic         ow_ack_request_out,
  input wire logic [4:0]   level_out
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  int unsigned low_q;
  int unsigned ramp_q;
  logic        pwm_run;
  assign pwm_run = (mode_out == BDC_MODE_PWM) && switch_enable_out && !ilim_half_out;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_q  <= 0;
      ramp_q <= 0;
    end else begin
      low_q  <= ctrl_pin_in ? 0 : low_q + 1;
      ramp_q <= ilim_half_out ? ramp_q + 1 : 0;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_ramp_done;
    $fell(ilim_half_out) ##0 switch_enable_out;
  endsequence
  // Switch must still be on a cycle later, so a byte that meets a cut-off in flight is not judged
  sequence s_ow_take;
    (ow_byte_valid_in && mode_out == BDC_MODE_ONE_WIRE && switch_enable_out && ow_byte_in.addr == OW_ADDR)
      ##1 switch_enable_out;
  endsequence
  AST_SW_SHUT: assert property (shutdown_out |-> !switch_enable_out)
    else $error("switch active in shutdown");
  AST_RAMP_ZERO: assert property ($rose(ilim_half_out) |-> switch_enable_out && ref_mv_out == 8'h00)
    else $error("ramp did not start from zero");
  AST_RAMP_LEN: assert property (s_ramp_done |-> ramp_q >= 32 * STEP_CYC && ramp_q <= 34 * STEP_CYC + 4)
    else $error("soft start length wrong");
  AST_LONG_LOW: assert property (low_q > SD_CYC + 6 |-> shutdown_out)
    else $error("long low did not shut down");
  AST_NO_EARLY_SD: assert property (!$past(shutdown_out) && low_q < SD_CYC |-> !shutdown_out)
    else $error("shutdown before the low time ran out");
  AST_UV_OT: assert property ((fault_in.uvlo || fault_in.otp) [*5] |-> !switch_enable_out)
    else $error("switch active under supply or heat fault");
  AST_OPEN: assert property ((fault_in.output_overvoltage_threshold && fault_in.fb_low) [*5] |-> !switch_enable_out)
    else $error("switch active with open string");
  AST_ACK: assert property (ow_byte_in.ack_request_bit ##0 s_ow_take |-> ##1 ow_ack_request_out)
    else $error("acknowledge request missed");
  AST_LEVEL: assert property (s_ow_take |-> ##1 level_out == $past(ow_byte_in.level, 2))
    else $error("level not stored");
  AST_BAD_ADDR: assert property (ow_byte_valid_in && ow_byte_in.addr != OW_ADDR |-> ##2 $stable(level_out))
    else $error("byte with wrong address taken");
  AST_PWM_HI: assert property ((ctrl_pin_in && pwm_run) [*6] |-> ref_mv_out == FULL_REF_MV)
    else $error("steady high pin not full scale");
  AST_PWM_LO: assert property ((!ctrl_pin_in && pwm_run) [*6] |-> ref_mv_out == 8'h00)
    else $error("low pin did not gate reference");
  AST_MODE_LOCK: assert property (!shutdown_out && !$past(shutdown_out) && !$past(shutdown_out, 2)
    && $past(mode_out) == BDC_MODE_ONE_WIRE |-> mode_out == BDC_MODE_ONE_WIRE)
    else $error("mode left one-wire while running");
endmodule

bind bdc_ctrl bdc_ctrl_monitor #(.STEP_CYC(STEP_CYC), .SD_CYC(SD_CYC)) u_mon (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .ctrl_pin_in(ctrl_pin_in), .fault_in(fault_in),
  .ow_byte_valid_in(ow_byte_valid_in), .ow_byte_in(ow_byte_in), .switch_enable_out(switch_enable_out),
  .ilim_half_out(ilim_half_out), .ref_mv_out(ref_mv_out), .shutdown_out(shutdown_out), .mode_out(mode_out),
  .ow_ack_request_out(ow_ack_request_out), .level_out(level_out));

// [verif/bdc_host_model.sv]
// Purpose: Host processor that drives the control pin
// Assumes: Pin changes just after a rising core clock edge
// Notes:   Pin has a pull-down, so low is also the released level
`timescale 1ns/1ps
module bdc_host_model #(
  parameter int unsigned SD_CYC = 200
) (
  // Clock
  input  wire logic core_clk_in,
  // Control pin
  output logic      ctrl_pin_out
);
  initial ctrl_pin_out = 1'b0;
  // Hold a level for n edges
  task automatic drive(input logic lvl, input int unsigned n);
    @(posedge core_clk_in);
    ctrl_pin_out <= lvl;
    repeat (n - 1) @(posedge core_clk_in);
  endtask
  // Margin over the low time, since the pin passes a synchroniser first
  task automatic shut_down();
    drive(1'b0, SD_CYC + 20);
  endtask
endmodule

// [verif/backlight_dimming_control_logic_tb_top.sv]
// Purpose: Self-checking bench for the dimming control block
// Assumes: Counts scaled down by parameters
// Notes:   Each scenario ends with the device shut down again
`timescale 1ns/1ps
module backlight_dimming_control_logic_tb_top;
  import bdc_pkg::*;
  localparam int unsigned STEP = 4, SD = 200, DLY = 10, LOW = 45, WIN = 200;
  logic         core_clk_in, reset_in, ctrl_pin, ow_byte_valid_in;
  bdc_fault_t   fault_in;
  bdc_ow_byte_t ow_byte_in;
  logic         sw_en, ilim, shut, latch, ack;
  logic [7:0]   ref_mv;
  logic [4:0]   level;
  bdc_mode_t    mode;
  int           num_errors = 0;
  int           n_tests = 0;

  bdc_ctrl #(.STEP_CYC(STEP), .SD_CYC(SD), .DELAY_CYC(DLY), .LOW_CYC(LOW), .WINDOW_CYC(WIN)) DUT (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .ctrl_pin_in(ctrl_pin), .fault_in(fault_in),
    .ow_byte_valid_in(ow_byte_valid_in), .ow_byte_in(ow_byte_in), .switch_enable_out(sw_en),
    .ilim_half_out(ilim), .ref_mv_out(ref_mv), .shutdown_out(shut), .mode_out(mode),
    .open_latch_out(latch), .ow_ack_request_out(ack), .level_out(level));
  bdc_host_model #(.SD_CYC(SD)) host (.core_clk_in(core_clk_in), .ctrl_pin_out(ctrl_pin));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wait_sw(input logic lvl);
    for (int n = 0; n < 500 && sw_en !== lvl; n++) cyc(1);
  endtask
  task automatic send(input bdc_ow_byte_t b, output int acks);
    acks = 0;
    @(posedge core_clk_in);
    ow_byte_valid_in <= 1'b1;
    ow_byte_in       <= b;
    @(posedge core_clk_in);
    ow_byte_valid_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      if (ack === 1'b1) acks++;
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pwm();
    int n;
    chk(8'(level), 8'h1F, "default level");
    host.drive(1'b1, 2);
    wait_sw(1'b1);
    chk(8'(ilim), 8'h01, "half limit");
    chk(ref_mv, 8'h00, "ramp start");
    for (n = 0; n < 1000 && ilim === 1'b1; n++) cyc(1);
    chk(8'(n >= 32 * STEP && n <= 34 * STEP + 4), 8'h01, "ramp length");
    chk(ref_mv, FULL_REF_MV, "steady high");
    chk(8'(mode), 8'h00, "pwm default");
    // Let the entry window run out first, or the long lows below would select one-wire
    cyc(WIN);
    chk(8'(mode), 8'h00, "pwm after window");
    repeat (3) begin
      host.drive(1'b0, 150);
      #1 chk(ref_mv, 8'h00, "low phase");
      host.drive(1'b1, 10);
      #1 chk(ref_mv, FULL_REF_MV, "high phase");
    end
    chk(8'(shut), 8'h00, "short lows");
    host.shut_down();
    #1 chk(8'(shut), 8'h01, "long low");
    chk(8'(sw_en), 8'h00, "switch off");
    $display("test pwm done");
  endtask
  task automatic t_ow();
    int a;
    host.drive(1'b1, DLY + 8);
    host.drive(1'b0, LOW + 10);
    #1 chk(8'(mode), 8'h01, "entry while low");
    host.drive(1'b1, 2);
    send('{1'b1, 2'h0, 5'h05}, a);
    chk(8'(level), 8'h05, "level written");
    chk(8'(a), 8'h01, "one ack");
    send('{1'b1, 2'h1, 5'h0A}, a);
    chk(8'(level), 8'h05, "bad address");
    chk(8'(a), 8'h00, "no ack");
    cyc(150);
    chk(ref_mv, 8'h11, "level 5 ref");
    host.shut_down();
    host.drive(1'b1, WIN + 20);
    #1 chk(8'(mode), 8'h00, "mode chosen anew");
    host.drive(1'b0, LOW + 10);
    host.drive(1'b1, 4);
    #1 chk(8'(mode), 8'h00, "late low");
    send('{1'b0, 2'h0, 5'h03}, a);
    chk(8'(level), 8'h05, "kept, pwm ignores byte");
    host.shut_down();
    $display("test one-wire done");
  endtask
  task automatic t_fault();
    host.drive(1'b1, 2);
    wait_sw(1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_in);
      fault_in <= (i == 0) ? 4'h8 : 4'h1;
      wait_sw(1'b0);
      chk(8'(sw_en), 8'h00, "fault off");
      @(posedge core_clk_in);
      fault_in <= 4'h0;
      wait_sw(1'b1);
      chk(8'(sw_en), 8'h01, "auto restart");
    end
    @(posedge core_clk_in);
    fault_in <= 4'h6;
    wait_sw(1'b0);
    chk(8'(latch), 8'h01, "open latched");
    @(posedge core_clk_in);
    fault_in <= 4'h0;
    host.drive(1'b0, 20);
    host.drive(1'b1, 20);
    #1 chk(8'(sw_en), 8'h00, "short low kept latch");
    host.shut_down();
    host.drive(1'b1, 2);
    wait_sw(1'b1);
    chk(8'(latch), 8'h00, "latch released");
    host.shut_down();
    $display("test faults done");
  endtask

  initial begin
    reset_in         = 1'b1;
    ow_byte_valid_in = 1'b0;
    ow_byte_in       = '0;
    fault_in         = '0;
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    cyc(4);
    t_pwm();
    t_ow();
    t_fault();
    end_sim();
  end
  // Whole run needs about 2600 cycles
  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    end_sim();
  end
endmodule
